// *** core/mtmp_pkg.sv ***
/*
 * mtmp_pkg: shared constants for the host-side controller of the
 * transmit half of a nibble-wide media independent interface and its
 * two-wire management port.
 * Assumes a 100 MHz system clock; all counts are derived from it here.
 */
package mtmp_pkg;

   // system clock
   localparam int CLK_PERIOD_NS = 10;

   // management clock limits
   localparam int MDC_MIN_HALF_NS = 160;
   localparam int MDC_MIN_PERIOD_NS = 400;
   // least times round up to whole cycles
   localparam int MDC_HALF_BY_PHASE = (MDC_MIN_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MDC_HALF_BY_PERIOD =
      (MDC_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
   localparam int MDC_HALF_CYC =
      (MDC_HALF_BY_PHASE > MDC_HALF_BY_PERIOD) ? MDC_HALF_BY_PHASE : MDC_HALF_BY_PERIOD;
   localparam int MDC_CNT_W = 8;

   // management frame layout, bit 0 goes out first
   localparam int MG_FRAME_BITS = 64;
   localparam int MG_PRE_BITS = 32;
   // field widths after the preamble
   localparam int MG_ST_BITS = 2;
   localparam int MG_OP_BITS = 2;
   localparam int MG_ADDR_BITS = 5;
   localparam int MG_TA_BITS = 2;
   localparam int MG_DATA_BITS = 16;
   localparam logic [5:0] MG_LAST_BIT = 6'h3F;
   localparam logic [5:0] MG_RD_RELEASE_BIT = 6'h2E;
   localparam logic [5:0] MG_DATA_FIRST_BIT = 6'h30;
   localparam logic [1:0] MG_START = 2'h1;
   localparam logic [1:0] MG_OP_WRITE = 2'h1;
   localparam logic [1:0] MG_OP_READ = 2'h2;
   localparam logic [1:0] MG_TA_WRITE = 2'h2;
   localparam logic [31:0] MG_PREAMBLE = 32'hFFFFFFFF;

   // role strap level that puts the module in phy role
   localparam logic ROLE_PHY_SIDE = 1'h0;

   // nibble driven while the enable is low
   localparam logic [3:0] TX_IDLE_NIBBLE = 4'h0;

endpackage

// *** core/mtmp_sync.sv ***
/*
 * mtmp_sync: two-flip-flop synchroniser for levels from pins.
 * Assumes each bit is an independent level; the first stage is read by
 * the second stage only.
 */
`timescale 1ns/100ps
module mtmp_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // asynchronous levels in, synchronised levels out
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } mtmp_sync_s;

   mtmp_sync_s st_r;
   mtmp_sync_s st_nxt;

   // shift one stage per clock
   always_comb begin
      st_nxt = st_r;
      st_nxt.stage1 = async_i;
      st_nxt.stage2 = st_r.stage1;
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sync_o = st_r.stage2;

endmodule

// *** core/mtmp_mdc_gen.sv ***
/*
 * mtmp_mdc_gen: free-running management clock divider.
 * Assumes the system clock of the package; gives the clock level and a
 * one-cycle pulse in the same cycle as each rise and each fall.
 */
`timescale 1ns/100ps
module mtmp_mdc_gen #(
   parameter int HALF_CYC = mtmp_pkg::MDC_HALF_CYC
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // management clock and its edge pulses
   output logic mdc_o,
   output logic rise_o,
   output logic fall_o
);

   localparam int HALF_LAST_I = HALF_CYC - 1;
   localparam logic [mtmp_pkg::MDC_CNT_W-1:0] HALF_LAST = HALF_LAST_I[mtmp_pkg::MDC_CNT_W-1:0];

   typedef struct packed {
      logic [mtmp_pkg::MDC_CNT_W-1:0] cnt;
      logic mdc;
      logic rise;
      logic fall;
   } mtmp_mdc_s;

   mtmp_mdc_s st_r;
   mtmp_mdc_s st_nxt;

   // equal high and low phases, each at least the least half period
   always_comb begin
      st_nxt = st_r;
      st_nxt.rise = 1'b0;
      st_nxt.fall = 1'b0;
      if (st_r.cnt == HALF_LAST) begin
         st_nxt.cnt = '0;
         st_nxt.mdc = ~st_r.mdc;
         st_nxt.rise = ~st_r.mdc;
         st_nxt.fall = st_r.mdc;
      end else begin
         st_nxt.cnt = st_r.cnt + 1'b1;
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign mdc_o = st_r.mdc;
   assign rise_o = st_r.rise;
   assign fall_o = st_r.fall;

endmodule

// *** core/mtmp_host.sv ***
/*
 * mtmp_host: mac-side controller for a module strapped to its phy role.
 * Feeds transmit nibbles timed by the module's transmit clock and runs
 * management read and write frames on the two-wire port.
 * Assumes an external pull-up on the management data wire and a
 * transmit clock slow enough to be sampled by the 100 MHz system clock.
 * Assumes the user holds valid and its nibble until ready is seen high,
 * and refills within one transmit clock period to keep a frame going.
 */
// How it works
// R1 - phy side supplies the continuous transmit clock that times enable and nibbles
// R2 - transmit clock is only an input here, never driven
// R3 - in isolate mode the phy side floats its transmit clock
// R4 - enable rises with first preamble nibble, stays high every frame nibble
// R5 - enable drops before the transmit clock edge after the last nibble
// R6 - enable changes only on transmit clock edges
// R7 - in isolate mode the phy side ignores the transmit enable
// R8 - this side makes the management clock; phases may stretch freely
// R9 - management clock phases at least 160 ns, period at least 400 ns
// R10 - phy side drives read data bits on the data wire timed by MDC
// R11 - this side drives control bits on the data wire timed by MDC
// R12 - management port gives read and write access to phy registers
// R13 - same pins in both roles, only directions change
// R14 - role strap sampled at reset: low phy role, high mac role
// R15 - clause 22 frame; the addressed side releases data when not driving
// R16 - new nibble every transmit clock while enabled, bit 0 on line zero
`timescale 1ns/100ps
module mtmp_host #(
   parameter int MDC_HALF_CYC = mtmp_pkg::MDC_HALF_CYC
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // transmit pins toward the module
   input wire logic tx_clock_i,
   output logic tx_enable_o,
   output logic [3:0] tx_nibble_o,
   // role strap toward the module
   output logic interface_role_select_o,
   // management pins
   output logic mdc_o,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe_n_o,
   // user nibble stream
   input wire logic user_valid_i,
   input wire logic [3:0] user_nibble_i,
   output logic user_ready_o,
   // user management command
   input wire logic mg_start_i,
   input wire logic mg_write_i,
   input wire logic [4:0] mg_phy_addr_i,
   input wire logic [4:0] mg_reg_addr_i,
   input wire logic [15:0] mg_wdata_i,
   output logic mg_busy_o,
   output logic mg_done_o,
   output logic [15:0] mg_rdata_o
);

   typedef enum logic [1:0] {
      MG_IDLE,
      MG_WAIT_FALL,
      MG_RUN
   } mtmp_mg_e;

   typedef struct packed {
      // transmit side
      logic tx_clk_prev;
      logic tx_en;
      logic [3:0] tx_nib;
      logic hold_full;
      logic [3:0] hold_nib;
      logic user_ready;
      // management side
      mtmp_mg_e mg_state;
      logic [5:0] bit_cnt;
      logic [mtmp_pkg::MG_FRAME_BITS-1:0] frame;
      logic is_write;
      logic mdio_out;
      logic mdio_oe_n;
      logic [15:0] rdata;
      logic done;
      logic busy;
      // strap
      logic role;
   } mtmp_host_s;

   mtmp_host_s st_r;
   mtmp_host_s st_nxt;

   logic tx_clk_s;
   logic mdio_s;
   logic mdc_rise;
   logic mdc_fall;
   logic tx_rise;
   logic [mtmp_pkg::MG_FRAME_BITS-1:0] frame_word;

   // frame field positions, counted from the first bit on the wire
   localparam int ST_POS = mtmp_pkg::MG_PRE_BITS;
   localparam int OP_POS = ST_POS + mtmp_pkg::MG_ST_BITS;
   localparam int PA_POS = OP_POS + mtmp_pkg::MG_OP_BITS;
   localparam int RA_POS = PA_POS + mtmp_pkg::MG_ADDR_BITS;
   localparam int TA_POS = RA_POS + mtmp_pkg::MG_ADDR_BITS;
   localparam int DA_POS = TA_POS + mtmp_pkg::MG_TA_BITS;
   localparam int PAIR_TOP = mtmp_pkg::MG_ST_BITS - 1;
   localparam int AD_TOP = mtmp_pkg::MG_ADDR_BITS - 1;
   localparam int DA_TOP = mtmp_pkg::MG_DATA_BITS - 1;

   // pins from outside pass two flip-flops before any logic
   // R1 R2 transmit clock only sampled, never driven
   mtmp_sync #(
      .WIDTH(1)
   ) u_sync_txclk (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .async_i(tx_clock_i),
      .sync_o(tx_clk_s)
   );

   // data wire seen through the same two-stage synchroniser
   mtmp_sync #(
      .WIDTH(1)
   ) u_sync_mdio (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .async_i(mdio_i),
      .sync_o(mdio_s)
   );

   // running free costs nothing: the module ignores it between frames
   // R8 R9 management clock limits
   mtmp_mdc_gen #(
      .HALF_CYC(MDC_HALF_CYC)
   ) u_mdc (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .mdc_o(mdc_o),
      .rise_o(mdc_rise),
      .fall_o(mdc_fall)
   );

   // prev resets low like the idle clock, so no false rise after reset
   // R3 R7 a floated clock gives no rises
   // R6 edge of transmit clock
   assign tx_rise = tx_clk_s & ~st_r.tx_clk_prev;

   // R15 clause 22 frame image, first bit in bit 0
   always_comb begin
      frame_word = '0;
      // preamble of ones goes out first
      frame_word[mtmp_pkg::MG_PRE_BITS-1:0] = mtmp_pkg::MG_PREAMBLE;
      // fields go out msb first, so each is placed bit by bit
      // start, opcode and turnaround share one width
      for (int i = 0; i < mtmp_pkg::MG_ST_BITS; i++) begin
         frame_word[ST_POS + i] = mtmp_pkg::MG_START[PAIR_TOP - i];
         frame_word[OP_POS + i] = mg_write_i ? mtmp_pkg::MG_OP_WRITE[PAIR_TOP - i] :
                                               mtmp_pkg::MG_OP_READ[PAIR_TOP - i];
         frame_word[TA_POS + i] = mg_write_i ? mtmp_pkg::MG_TA_WRITE[PAIR_TOP - i] : 1'b1;
      end
      for (int i = 0; i < mtmp_pkg::MG_ADDR_BITS; i++) begin
         frame_word[PA_POS + i] = mg_phy_addr_i[AD_TOP - i];
         frame_word[RA_POS + i] = mg_reg_addr_i[AD_TOP - i];
      end
      // read turnaround and data stay high; the wire is released there
      for (int i = 0; i < mtmp_pkg::MG_DATA_BITS; i++) begin
         frame_word[DA_POS + i] = mg_write_i ? mg_wdata_i[DA_TOP - i] : 1'b1;
      end
   end

   // next state of the whole controller
   always_comb begin
      st_nxt = st_r;
      st_nxt.tx_clk_prev = tx_clk_s;
      st_nxt.done = 1'b0;
      // the module must see the phy role at its own reset
      st_nxt.role = mtmp_pkg::ROLE_PHY_SIDE;

      // one entry is enough: a transmit period spans many system cycles
      // one-entry holding stage between user and pins
      if (st_r.user_ready && user_valid_i) begin
         st_nxt.hold_full = 1'b1;
         st_nxt.hold_nib = user_nibble_i;
         st_nxt.user_ready = 1'b0;
      end

      // R6 pins change only just after a transmit clock rise
      if (tx_rise) begin
         if (st_r.hold_full) begin
            // R4 enable high with every nibble
            st_nxt.tx_en = 1'b1;
            // R16 one nibble per clock, bit 0 on line zero
            st_nxt.tx_nib = st_r.hold_nib;
            st_nxt.hold_full = 1'b0;
            // the stage empties, so the user may refill at once
            st_nxt.user_ready = 1'b1;
         end else begin
            // R5 enable drops at the edge after the last nibble
            st_nxt.tx_en = 1'b0;
            st_nxt.tx_nib = mtmp_pkg::TX_IDLE_NIBBLE;
            // a nibble taken in this very cycle keeps the stage full
            st_nxt.user_ready = !(st_r.user_ready && user_valid_i);
         end
      end

      // management frame sequencer
      case (st_r.mg_state)
         MG_IDLE: begin
            // R15 data wire released while idle
            st_nxt.mdio_oe_n = 1'b1;
            st_nxt.mdio_out = 1'b1;
            // inputs are captured here, so they may change during the frame
            if (mg_start_i) begin
               st_nxt.frame = frame_word;
               st_nxt.is_write = mg_write_i;
               st_nxt.busy = 1'b1;
               st_nxt.bit_cnt = '0;
               st_nxt.mg_state = MG_WAIT_FALL;
            end
         end
         MG_WAIT_FALL: begin
            // waiting for a fall keeps the first bit a full period wide
            // R11 first bit set up after a falling edge
            if (mdc_fall) begin
               st_nxt.mdio_out = st_r.frame[0];
               st_nxt.mdio_oe_n = 1'b0;
               st_nxt.frame = st_r.frame >> 1;
               st_nxt.mg_state = MG_RUN;
            end
         end
         MG_RUN: begin
            // synced data lags two cycles, far inside the half period
            // R10 read bits sampled on rising edges of the data phase
            if (mdc_rise && !st_r.is_write &&
                st_r.bit_cnt >= mtmp_pkg::MG_DATA_FIRST_BIT) begin
               st_nxt.rdata = {st_r.rdata[14:0], mdio_s};
            end
            if (mdc_fall) begin
               if (st_r.bit_cnt == mtmp_pkg::MG_LAST_BIT) begin
                  // done and busy move together, so a new start may follow
                  // R15 release after the last data bit
                  st_nxt.mdio_oe_n = 1'b1;
                  st_nxt.mdio_out = 1'b1;
                  st_nxt.busy = 1'b0;
                  st_nxt.done = 1'b1;
                  st_nxt.mg_state = MG_IDLE;
               end else begin
                  st_nxt.bit_cnt = st_r.bit_cnt + 1'b1;
                  // R11 control bits change on falling edges
                  st_nxt.mdio_out = st_r.frame[0];
                  st_nxt.frame = st_r.frame >> 1;
                  // the phy drives the second turnaround bit, never both sides
                  // R15 read turnaround and data left to the phy
                  if (!st_r.is_write &&
                      st_r.bit_cnt + 1'b1 >= mtmp_pkg::MG_RD_RELEASE_BIT) begin
                     st_nxt.mdio_oe_n = 1'b1;
                     st_nxt.mdio_out = 1'b1;
                  end
               end
            end
         end
         default: begin
            // an illegal state drops the frame and frees the wire
            st_nxt.mg_state = MG_IDLE;
            st_nxt.busy = 1'b0;
            st_nxt.mdio_oe_n = 1'b1;
         end
      endcase
   end

   // single register bank; everything takes a constant at reset
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_r <= '{
            tx_clk_prev: 1'b0,
            tx_en: 1'b0,
            tx_nib: mtmp_pkg::TX_IDLE_NIBBLE,
            hold_full: 1'b0,
            hold_nib: 4'h0,
            user_ready: 1'b0,
            mg_state: MG_IDLE,
            bit_cnt: 6'h0,
            frame: '0,
            is_write: 1'b0,
            mdio_out: 1'b1,
            mdio_oe_n: 1'b1,
            rdata: 16'h0000,
            done: 1'b0,
            busy: 1'b0,
            role: mtmp_pkg::ROLE_PHY_SIDE
         };
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs come straight from the register bank
   assign tx_enable_o = st_r.tx_en;
   assign tx_nibble_o = st_r.tx_nib;
   assign interface_role_select_o = st_r.role;

   // management and user side outputs, also registered
   assign mdio_o = st_r.mdio_out;
   assign mdio_oe_n_o = st_r.mdio_oe_n;
   assign user_ready_o = st_r.user_ready;
   assign mg_busy_o = st_r.busy;
   assign mg_done_o = st_r.done;
   assign mg_rdata_o = st_r.rdata;

endmodule

// *** tb/mtmp_host_monitor.sv ***
/* mtmp_host_monitor: port-level checks on the host controller.
   Assumes a transmit clock of at least 12 system clock cycles. */
`timescale 1ns/100ps
module mtmp_host_monitor #(
   parameter int MDC_HALF_CYC = mtmp_pkg::MDC_HALF_CYC
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // transmit side
   input wire logic tx_clock_i,
   input wire logic tx_enable_o,
   input wire logic [3:0] tx_nibble_o,
   input wire logic user_valid_i,
   input wire logic user_ready_o,
   // management side
   input wire logic mdc_o,
   input wire logic mdio_o,
   input wire logic mdio_oe_n_o,
   input wire logic mg_start_i,
   input wire logic mg_busy_o,
   input wire logic mg_done_o
);
   localparam int BUSY_LO = 128 * MDC_HALF_CYC - 4;
   localparam int BUSY_HI = 130 * MDC_HALF_CYC + 4;
   logic mdc_q_r;
   logic seen_r;
   logic [7:0] run_r;
   logic [15:0] busy_r;
   // counters, since phase and frame lengths exceed repetition limits
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mdc_q_r <= 1'h0;
         seen_r <= 1'h0;
         run_r <= 8'h00;
         busy_r <= 16'h0000;
      end else begin
         mdc_q_r <= mdc_o;
         seen_r <= seen_r | (mdc_o != mdc_q_r);
         run_r <= (mdc_o != mdc_q_r) ? 8'h01 : run_r + 8'h01;
         busy_r <= mg_busy_o ? busy_r + 16'h0001 : 16'h0000;
      end
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   // stream pins move only just after a transmit clock rise
   chk_en_sync: assert property (
      $changed(tx_enable_o) |-> $past(tx_clock_i, 2) && !$past(tx_clock_i, 6))
      else $error("enable changed away from a clock rise");
   chk_nib_sync: assert property (
      $changed(tx_nibble_o) |-> $past(tx_clock_i, 2) && !$past(tx_clock_i, 6))
      else $error("nibble changed away from a clock rise");
   chk_en_end: assert property ($fell(tx_enable_o) |-> $past(user_ready_o))
      else $error("enable dropped with a nibble held");
   chk_take_drop: assert property (
      user_ready_o && user_valid_i |=> !user_ready_o)
      else $error("ready stayed up after a take");
   chk_idle_nibble: assert property (
      !tx_enable_o |-> tx_nibble_o == mtmp_pkg::TX_IDLE_NIBBLE)
      else $error("nibble not idle while enable low");
   // management clock shape
   chk_mdc_phase: assert property (
      mdc_o != mdc_q_r && seen_r |-> run_r == MDC_HALF_CYC)
      else $error("management clock phase length wrong");
   chk_mdc_runs: assert property (seen_r |-> run_r <= MDC_HALF_CYC)
      else $error("management clock stopped");
   // management data wire
   chk_mdio_fall: assert property (
      $changed(mdio_o) || $changed(mdio_oe_n_o) |-> !mdc_o && $past(mdc_o, 3))
      else $error("data wire moved outside the low phase");
   chk_done_len: assert property (
      mg_done_o |-> $fell(mg_busy_o) && busy_r >= BUSY_LO && busy_r <= BUSY_HI)
      else $error("frame length wrong");
   chk_start_busy: assert property (mg_start_i && !mg_busy_o |=> mg_busy_o)
      else $error("idle start not taken");
   chk_idle_free: assert property (!mg_busy_o |-> mdio_oe_n_o && mdio_o)
      else $error("data wire driven while idle");
endmodule
bind mtmp_host mtmp_host_monitor #(.MDC_HALF_CYC(MDC_HALF_CYC)) u_mon (.mclk_i(mclk_i),
   .resetn_i(resetn_i), .tx_clock_i(tx_clock_i), .tx_enable_o(tx_enable_o),
   .tx_nibble_o(tx_nibble_o), .user_valid_i(user_valid_i), .user_ready_o(user_ready_o),
   .mdc_o(mdc_o), .mdio_o(mdio_o), .mdio_oe_n_o(mdio_oe_n_o), .mg_start_i(mg_start_i),
   .mg_busy_o(mg_busy_o), .mg_done_o(mg_done_o));

// *** tb/mtmp_phy_model.sv ***
/* mtmp_phy_model: behavioural module strapped to its phy role.
   Assumes the bench resolves the data wire with a pull-up. */
`timescale 1ns/100ps
module mtmp_phy_model #(
   parameter logic [4:0] PHY_ADDR = 5'h03
) (
   // straps
   input wire logic isolate_i,
   input wire logic role_i,
   // transmit clock out
   output logic tx_clock_o,
   // management pins
   input wire logic mdc_i,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe_n_o
);
   logic clk_r = 1'h0;
   logic prev_r = 1'h1;
   logic [15:0] regs [32];
   logic [15:0] sh_r;
   logic [11:0] hdr_r;
   int cnt = 0;
   int rcnt = 0;
   // continuous clock, phase unrelated to the system clock
   initial begin
      for (int i = 0; i < 32; i++) regs[i] = 16'hC300 + 16'(i);
      mdio_o = 1'h1;
      mdio_oe_n_o = 1'h1;
      #37;
      forever #80 clk_r = ~clk_r;
   end
   // clock floated in isolate mode or mac role; enable never used
   assign tx_clock_o = (isolate_i || role_i) ? 1'bz : clk_r;
   always @(posedge mdc_i) begin
      if (rcnt == 0 && cnt == 0) begin
         if (!prev_r && mdio_i) cnt = 1;
         prev_r = mdio_i;
      end else if (rcnt == 0) begin
         sh_r = {sh_r[14:0], mdio_i};
         cnt++;
         if (cnt == 13) begin
            hdr_r = sh_r[11:0];
            if (hdr_r[11:10] == 2'h2) begin
               rcnt = (hdr_r[9:5] == PHY_ADDR) ? 1 : 0;
               cnt = 0;
               prev_r = 1'h1;
            end
         end
         if (cnt == 31) begin
            if (hdr_r[9:5] == PHY_ADDR) regs[hdr_r[4:0]] = sh_r;
            cnt = 0;
            prev_r = 1'h1;
         end
      end
   end
   // read reply after each fall, released around it
   always @(negedge mdc_i) begin
      if (rcnt > 0) begin
         rcnt++;
         mdio_oe_n_o = !(rcnt >= 3 && rcnt <= 19);
         mdio_o = (rcnt >= 4 && rcnt <= 19) ? regs[hdr_r[4:0]][19 - rcnt] : 1'h0;
         if (rcnt == 20) rcnt = 0;
      end
   end
endmodule

// *** tb/mtmp_host_test.sv ***
/* mtmp_host_test: bench for the host controller and a phy model.
   Assumes nothing outside; it makes clock, reset and the pull-up. */
`timescale 1ns/100ps
module mtmp_host_test;
   localparam logic [4:0] PA = 5'h03;
   logic mclk_i = 1'h0, resetn_i = 1'h0, user_valid_i = 1'h0, mg_start_i = 1'h0;
   logic mg_write_i = 1'h0, tx_clock_i, tx_enable_o, interface_role_select_o;
   logic mdc_o, mdio_i, mdio_o, mdio_oe_n_o, user_ready_o, mg_busy_o, mg_done_o;
   logic phy_do, phy_oe_n;
   logic [3:0] user_nibble_i = 4'h0, tx_nibble_o;
   logic [4:0] mg_phy_addr_i = 5'h00, mg_reg_addr_i = 5'h00;
   logic [15:0] mg_wdata_i = 16'h0000, mg_rdata_o, w;
   logic [16:0] r;
   logic [3:0] nq [$];
   logic [16:0] rq [$];
   int error_cnt = 0, n_compared = 0, cyc = 0;
   mtmp_host DUT (.*);
   mtmp_phy_model #(.PHY_ADDR(PA)) PHY (.isolate_i(1'h0), .role_i(interface_role_select_o),
      .tx_clock_o(tx_clock_i), .mdc_i(mdc_o), .mdio_i(mdio_i), .mdio_o(phy_do),
      .mdio_oe_n_o(phy_oe_n));
   // wire with pull-up: released means high
   assign mdio_i = !mdio_oe_n_o ? mdio_o : (!phy_oe_n ? phy_do : 1'h1);
   always #5 mclk_i = ~mclk_i;
   task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // hang guard, well above the longest sequence
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         finish_test;
      end
   end
   // nibble watcher: one note per enabled clock rise
   always @(posedge tx_clock_i) begin
      if (tx_enable_o === 1'h1 && nq.size() == 0) cmp("spare nibble", 16'h0, 16'h1);
      else if (tx_enable_o === 1'h1) cmp("nibble", 16'(nq.pop_front()), 16'(tx_nibble_o));
   end
   // frame watcher: one note per read or spare done pulse
   always @(posedge mclk_i) begin
      if (mg_done_o === 1'h1) begin
         if (rq.size() == 0) cmp("spare done", 16'h0, 16'h1);
         else begin
            r = rq.pop_front();
            if (r[16]) cmp("read data", r[15:0], mg_rdata_o);
         end
      end
   end
   task automatic send_frame(int n);
      for (int i = 0; i < n; i++) begin
         nq.push_back(4'($urandom));
         @(posedge mclk_i);
         user_valid_i <= 1'h1;
         user_nibble_i <= nq[nq.size() - 1];
         do @(posedge mclk_i); while (user_ready_o !== 1'h1);
      end
      @(posedge mclk_i);
      user_valid_i <= 1'h0;
      repeat (40 + $urandom % 40) @(posedge mclk_i);
      cmp("enable after frame", 16'h0, 16'(tx_enable_o));
      cmp("nibbles left", 16'h0, 16'(nq.size()));
   endtask
   // one frame, with a refused write start four cycles after the frame is taken
   task automatic mg(logic wr, logic [4:0] pa, logic [4:0] ra, logic [15:0] wd, logic [16:0] nt);
      rq.push_back(nt);
      @(posedge mclk_i);
      mg_start_i <= 1'h1;
      mg_write_i <= wr;
      mg_phy_addr_i <= pa;
      mg_reg_addr_i <= ra;
      mg_wdata_i <= wd;
      @(posedge mclk_i);
      mg_start_i <= 1'h0;
      repeat (3) @(posedge mclk_i);
      mg_start_i <= 1'h1;
      mg_write_i <= 1'h1;
      mg_reg_addr_i <= 5'h05;
      mg_wdata_i <= ~w;
      @(posedge mclk_i);
      mg_start_i <= 1'h0;
      do @(posedge mclk_i); while (mg_done_o !== 1'h1);
   endtask
   initial begin
      w = 16'($urandom(32'h81CD));
      repeat (3) @(posedge mclk_i);
      resetn_i <= 1'h1;
      cmp("role strap", 16'(mtmp_pkg::ROLE_PHY_SIDE), 16'(interface_role_select_o));
      $display("role strap test done");
      fork
         begin
            for (int f = 0; f < 3; f++) send_frame(f == 0 ? 1 : 8 * f);
            $display("transmit frames done");
         end
         begin
            mg(1'h1, PA, 5'h05, w, 17'h00000);
            mg(1'h0, PA, 5'h05, 16'h0000, {1'h1, w});
            mg(1'h0, PA, 5'h1F, 16'h0000, 17'h1C31F);
            mg(1'h0, PA + 5'h01, 5'h00, 16'h0000, 17'h1FFFF);
            $display("management frames done");
         end
      join
      finish_test;
   end
endmodule
